// [esc_pkg.sv]
package esc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned NUM_SPACES             = 4;
  localparam logic [11:0] OFS_SPACE_WIDTH_SELECT = 12'h000;
  localparam logic [11:0] OFS_SPACE_CYCLE_TIMING = 12'h004;

  // Reset values, applied by power-on reset and hardware standby only
  localparam logic [15:0] RST_SPACE_WIDTH_SELECT = 16'h000F;
  localparam logic [15:0] RST_SPACE_CYCLE_TIMING = 16'hFFFF;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned POS_SPACE_WIDTH = 0;
  localparam int unsigned POS_IDLE        = 8;
  localparam int unsigned POS_SAME_IDLE   = 4;
  localparam int unsigned POS_ASSERT_EXT  = 0;
  localparam int unsigned IDLE_FIELD_W    = 2;

  // Saturation value of the elapsed idle counter
  localparam logic [1:0]  IDLE_COUNT_MAX  = 2'h3;

  // ****************************************************************
  // Bus cycle sequencer states, Gray coded along the access path
  // ****************************************************************
  typedef enum logic [2:0] {
    ESC_ST_IDLE   = 3'h0,
    ESC_ST_GAP    = 3'h1,
    ESC_ST_PRE    = 3'h3,
    ESC_ST_STROBE = 3'h2,
    ESC_ST_POST   = 3'h6
  } esc_state_e;

endpackage

// [esc_gap.sv]
module esc_gap (
  input  wire logic [15:0] timing,
  input  wire logic        prev_valid,
  input  wire logic        prev_read,
  input  wire logic [1:0]  prev_space,
  input  wire logic [1:0]  next_space,
  input  wire logic        next_write,
  input  wire logic [1:0]  elapsed,
  output logic      [1:0]  remaining
);

  // ****************************************************************
  // Idle cycles still owed before the next access may start
  // ****************************************************************

  logic [1:0] iw;
  logic [1:0] cw;
  logic [1:0] need;

  // Fields of the previous space, then the gap it demands
  always_comb begin
    iw   = timing[esc_pkg::POS_IDLE + esc_pkg::IDLE_FIELD_W * prev_space +: 2];
    cw   = {1'b0, timing[esc_pkg::POS_SAME_IDLE + prev_space]};
    need = 2'h0;
    if (prev_valid) begin
      if (prev_space != next_space) begin
        need = prev_read ? iw : 2'h0;
      end else if (prev_read && next_write) begin
        need = (iw > cw) ? iw : cw;
      end else begin
        need = cw;
      end
    end
    // Idle cycles already spent on the bus count toward the gap
    remaining = (need > elapsed) ? 2'(need - elapsed) : 2'h0;
  end

endmodule

// [esc_space_timing.sv]
// Contract
// - Width register 16 bits, resets 0x000F on power-on; manual reset keeps it.
// - Width register bits 15 to 4 always read zero.
// - Width bit n: 0 gives byte bus, 1 gives word bus; resets word.
// - Space 0 width from register only with ROM enabled, else mode pin.
// - Timing register 16 bits, resets 0xFFFF on power-on; manual reset keeps it.
// - After a read, access to another space gets the programmed idle cycles.
// - Same-space read followed by write also gets idle cycles.
// - Idle count comes from the previous access's space.
// - Two-bit idle field per space in bits 15:8; codes give 0 to 3.
// - Same-space idle bit adds one chip-select-off cycle between accesses.
// - Same-space write after read inserts the larger of both idle counts.
// - Assert extension adds one cycle before and after each strobe.
// - Strobes never outlast the accessed space's chip select.
module esc_space_timing (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        manual_rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rom_enabled,
  input  wire logic        mode_space0_word,
  input  wire logic        acc_valid,
  input  wire logic [1:0]  acc_space,
  input  wire logic        acc_write,
  input  wire logic        acc_upper,
  input  wire logic        acc_lower,
  output logic             acc_ready,
  output logic      [3:0]  space_select_n,
  output logic             read_strobe_n,
  output logic             write_strobe_upper_n,
  output logic             write_strobe_lower_n,
  output logic             bus_word
);

  // ****************************************************************
  // State
  // ****************************************************************

  typedef struct packed {
    logic [3:0]          width;
    logic [15:0]         timing;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    esc_pkg::esc_state_e st;
    logic [1:0]          gap_cnt;
    logic [1:0]          elapsed;
    logic                prev_valid;
    logic                prev_read;
    logic [1:0]          prev_space;
    logic [1:0]          cur_space;
    logic                cur_write;
    logic                cur_upper;
    logic                cur_lower;
    logic                cur_ext;
    logic [3:0]          cs_n;
    logic                rd_n;
    logic                wru_n;
    logic                wrl_n;
    logic                word;
    logic                ready;
  } esc_regs_s;

  localparam esc_regs_s RESET_VAL = '{
    width:   esc_pkg::RST_SPACE_WIDTH_SELECT[3:0],
    timing:  esc_pkg::RST_SPACE_CYCLE_TIMING,
    st:      esc_pkg::ESC_ST_IDLE,
    cs_n:    4'hF,
    rd_n:    1'b1,
    wru_n:   1'b1,
    wrl_n:   1'b1,
    word:    1'b1,
    ready:   1'b1,
    default: '0
  };

  esc_regs_s q;
  esc_regs_s d;

  logic       apb_setup;
  logic       apb_wr;
  logic       hit_width;
  logic       hit_timing;
  logic       take;
  logic [1:0] elapsed_eff;
  logic [1:0] gap_rem;
  logic       ext_new;
  logic       word_new;

  // ****************************************************************
  // Decode and access launch terms
  // ****************************************************************

  // Register hits and handshake qualifiers
  assign apb_setup   = psel && !penable;
  assign apb_wr      = psel && penable && q.pready && pwrite;
  assign hit_width   = (paddr == esc_pkg::OFS_SPACE_WIDTH_SELECT);
  assign hit_timing  = (paddr == esc_pkg::OFS_SPACE_CYCLE_TIMING);
  assign take        = acc_valid && q.ready;

  // The idle cycle in which a request is taken already counts as bus idle
  assign elapsed_eff = (q.st != esc_pkg::ESC_ST_IDLE) ? 2'h0 :
                       (q.elapsed == esc_pkg::IDLE_COUNT_MAX) ? esc_pkg::IDLE_COUNT_MAX :
                       2'(q.elapsed + 2'h1);

  // Per-space options for the incoming access
  assign ext_new  = q.timing[esc_pkg::POS_ASSERT_EXT + acc_space];
  assign word_new = (acc_space == 2'h0 && !rom_enabled) ? mode_space0_word :
                    q.width[esc_pkg::POS_SPACE_WIDTH + acc_space];

  // Gap owed to the access that finished last
  esc_gap u_gap (
    .timing     (q.timing),
    .prev_valid (q.prev_valid),
    .prev_read  (q.prev_read),
    .prev_space (q.prev_space),
    .next_space (acc_space),
    .next_write (acc_write),
    .elapsed    (elapsed_eff),
    .remaining  (gap_rem)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************

  // Register file, sequencer and pin shaping
  always_comb begin
    d = q;

    // APB answers one cycle after setup with data captured at setup
    d.pready = apb_setup;
    if (apb_setup) begin
      d.pslverr = !(hit_width || hit_timing);
      if (hit_width) begin
        d.prdata = {28'h0000000, q.width};
      end else if (hit_timing) begin
        d.prdata = {16'h0000, q.timing};
      end else begin
        d.prdata = 32'h00000000;
      end
    end
    // Upper width bits are dropped; software must not change it after init
    if (apb_wr && hit_width && pstrb[0]) begin
      d.width = pwdata[3:0];
    end
    if (apb_wr && hit_timing && pstrb[0]) begin
      d.timing[7:0] = pwdata[7:0];
    end
    if (apb_wr && hit_timing && pstrb[1]) begin
      d.timing[15:8] = pwdata[15:8];
    end

    // Sequencer moves on when no new request is taken
    unique case (q.st)
      esc_pkg::ESC_ST_IDLE: begin
        if (q.elapsed != esc_pkg::IDLE_COUNT_MAX) begin
          d.elapsed = 2'(q.elapsed + 2'h1);
        end
      end
      esc_pkg::ESC_ST_GAP: begin
        if (q.gap_cnt == 2'h1) begin
          d.st = q.cur_ext ? esc_pkg::ESC_ST_PRE : esc_pkg::ESC_ST_STROBE;
        end else begin
          d.gap_cnt = 2'(q.gap_cnt - 2'h1);
        end
      end
      esc_pkg::ESC_ST_PRE: begin
        d.st = esc_pkg::ESC_ST_STROBE;
      end
      esc_pkg::ESC_ST_STROBE: begin
        d.elapsed = 2'h0;
        d.st      = q.cur_ext ? esc_pkg::ESC_ST_POST : esc_pkg::ESC_ST_IDLE;
      end
      esc_pkg::ESC_ST_POST: begin
        d.elapsed = 2'h0;
        d.st      = esc_pkg::ESC_ST_IDLE;
      end
    endcase

    // A taken request starts with its owed gap, then the optional lead cycle
    if (take) begin
      d.cur_space = acc_space;
      d.cur_write = acc_write;
      d.cur_upper = acc_upper;
      d.cur_lower = acc_lower;
      d.cur_ext   = ext_new;
      d.word      = word_new;
      d.elapsed   = 2'h0;
      if (gap_rem != 2'h0) begin
        d.st      = esc_pkg::ESC_ST_GAP;
        d.gap_cnt = gap_rem;
      end else begin
        d.st      = ext_new ? esc_pkg::ESC_ST_PRE : esc_pkg::ESC_ST_STROBE;
      end
    end

    // The access in its strobe cycle becomes the reference for the next gap
    if (d.st == esc_pkg::ESC_ST_STROBE) begin
      d.prev_valid = 1'b1;
      d.prev_read  = !d.cur_write;
      d.prev_space = d.cur_space;
    end

    // Manual reset stops the bus but leaves both registers alone
    if (!manual_rst_n) begin
      d.st         = esc_pkg::ESC_ST_IDLE;
      d.elapsed    = 2'h0;
      d.gap_cnt    = 2'h0;
      d.prev_valid = 1'b0;
    end

    // Pins follow the next state so that they leave flip-flops directly
    d.cs_n = 4'hF;
    if (d.st == esc_pkg::ESC_ST_PRE || d.st == esc_pkg::ESC_ST_STROBE || d.st == esc_pkg::ESC_ST_POST) begin
      d.cs_n[d.cur_space] = 1'b0;
    end
    d.rd_n  = !(d.st == esc_pkg::ESC_ST_STROBE && !d.cur_write);
    d.wru_n = !(d.st == esc_pkg::ESC_ST_STROBE && d.cur_write && d.cur_upper && d.word);
    d.wrl_n = !(d.st == esc_pkg::ESC_ST_STROBE && d.cur_write &&
                (d.word ? d.cur_lower : (d.cur_lower || d.cur_upper)));
    d.ready = (d.st == esc_pkg::ESC_ST_IDLE) || (d.st == esc_pkg::ESC_ST_POST) ||
              (d.st == esc_pkg::ESC_ST_STROBE && !d.cur_ext);
  end

  // Power-on reset and hardware standby reach every flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RESET_VAL;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Straight from the state register
  assign prdata               = q.prdata;
  assign pready               = q.pready;
  assign pslverr              = q.pslverr;
  assign acc_ready            = q.ready;
  assign space_select_n       = q.cs_n;
  assign read_strobe_n        = q.rd_n;
  assign write_strobe_upper_n = q.wru_n;
  assign write_strobe_lower_n = q.wrl_n;
  assign bus_word             = q.word;

  // ****************************************************************
  // Checks
  // ****************************************************************

  logic [2:0] h_idle_run;
  logic       h_all_high;
  logic       h_seen;
  logic       h_last_read;
  logic [1:0] h_last_space;
  logic       h_strobe;
  logic       h_cs_start;
  logic       h_width_sel;
  logic [1:0] h_last_iw;
  logic       h_last_cw;

  // Helper terms seen from the pins and read from the width and timing registers
  assign h_strobe    = !read_strobe_n || !write_strobe_upper_n || !write_strobe_lower_n;
  assign h_cs_start  = h_all_high && !(&space_select_n);
  assign h_width_sel = q.width[acc_space];
  assign h_last_iw   = q.timing[esc_pkg::POS_IDLE + esc_pkg::IDLE_FIELD_W * h_last_space +: 2];
  assign h_last_cw   = q.timing[esc_pkg::POS_SAME_IDLE + h_last_space];

  // Run of chip-select-off cycles and the last strobed access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_idle_run   <= 3'h0;
      h_all_high   <= 1'b1;
      h_seen       <= 1'b0;
      h_last_read  <= 1'b0;
      h_last_space <= 2'h0;
    end else begin
      h_all_high <= &space_select_n;
      if (&space_select_n) begin
        h_idle_run <= (h_idle_run == 3'h7) ? 3'h7 : 3'(h_idle_run + 3'h1);
      end else begin
        h_idle_run <= 3'h0;
      end
      if (!manual_rst_n) begin
        h_seen <= 1'b0;
      end else if (h_strobe) begin
        h_seen       <= 1'b1;
        h_last_read  <= !read_strobe_n;
        h_last_space <= q.cur_space;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !manual_rst_n);

  sequence s_ext_lead;
    !space_select_n[q.cur_space] && !h_strobe;
  endsequence

  sequence s_strobe_in_cs;
    !space_select_n[q.cur_space] && h_strobe;
  endsequence

  AST_WIDTH_READ_ZERO: assert property (
    (psel && penable && pready && !pwrite && hit_width) |-> (prdata == {28'h0000000, q.width}))
    else $error("width register read shows reserved bits or wrong value");

  AST_WIDTH_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !(apb_wr && hit_width) |=> $stable(q.width))
    else $error("width register changed without a bus write");

  AST_TIMING_WRITE: assert property (
    (apb_wr && hit_timing && pstrb == 4'hF) |=> (q.timing == $past(pwdata[15:0])))
    else $error("timing register did not take the written value");

  AST_SPACE0_MODE_PIN: assert property (
    (take && acc_space == 2'h0 && !rom_enabled) |=> (bus_word == $past(mode_space0_word)))
    else $error("space 0 width ignored the mode pin");

  AST_SPACE_WIDTH: assert property (
    (take && (acc_space != 2'h0 || rom_enabled)) |=> (bus_word == $past(h_width_sel)))
    else $error("bus width does not follow the width register");

  AST_STROBE_IN_CS: assert property (
    h_strobe |-> (!space_select_n[q.cur_space] && $countones(~space_select_n) == 1))
    else $error("strobe active outside its chip select");

  AST_EXT_FRAME: assert property (
    (q.st == esc_pkg::ESC_ST_PRE) |-> s_ext_lead ##1 s_strobe_in_cs ##1 s_ext_lead)
    else $error("assert extension cycles missing around strobe");

  AST_GAP_OTHER_SPACE: assert property (
    (h_cs_start && h_seen && h_last_read && q.cur_space != h_last_space) |->
      (h_idle_run >= {1'b0, h_last_iw}))
    else $error("too few idle cycles after read before other space");

  AST_GAP_READ_WRITE: assert property (
    (h_cs_start && h_seen && h_last_read && q.cur_write && q.cur_space == h_last_space) |->
      (h_idle_run >= {1'b0, h_last_iw} && h_idle_run >= {2'h0, h_last_cw}))
    else $error("read then write in same space got too few idle cycles");

  AST_GAP_SAME_SPACE: assert property (
    (h_seen && h_strobe && h_last_cw && q.cur_space == h_last_space && $past(h_strobe)) |-> 1'b0)
    else $error("same space accesses ran together despite idle bit");

endmodule

// [esc_ext_mem_model.sv]
// ****************************************************************
// Passive model of the devices on the four chip-select spaces
// ****************************************************************
module esc_ext_mem_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [3:0]  space_select_n,
  input  wire logic        read_strobe_n,
  input  wire logic        write_strobe_upper_n,
  input  wire logic        write_strobe_lower_n,
  input  wire logic        bus_word,
  output logic      [15:0] strobe_cnt,
  output logic      [7:0]  last_gap,
  output logic      [3:0]  last_lead,
  output logic      [3:0]  last_trail,
  output logic      [3:0]  last_cs_n,
  output logic      [2:0]  last_kind,
  output logic             last_word,
  output logic      [7:0]  outside_cnt
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] idle_q;
  logic [3:0] run_q;
  logic [3:0] prev_cs_n_q;
  logic       trail_open_q;
  logic       strobe;
  logic [3:0] run_now;

  // Any strobe low marks one transfer; the lead count includes this cycle
  assign strobe  = !(read_strobe_n && write_strobe_upper_n && write_strobe_lower_n);
  assign run_now = (space_select_n == prev_cs_n_q) ? run_q + 4'h1 : 4'h1;

  // Record gap, lead, trail, lanes and width of each transfer as a device sees them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_q       <= 8'h00;
      run_q        <= 4'h0;
      prev_cs_n_q  <= 4'hF;
      trail_open_q <= 1'b0;
      strobe_cnt   <= 16'h0000;
      last_gap     <= 8'h00;
      last_lead    <= 4'h0;
      last_trail   <= 4'h0;
      last_cs_n    <= 4'hF;
      last_kind    <= 3'h0;
      last_word    <= 1'b0;
      outside_cnt  <= 8'h00;
    end else begin
      prev_cs_n_q <= space_select_n;
      run_q       <= (space_select_n == 4'hF) ? 4'h0 : run_now;
      if (strobe) begin
        idle_q       <= 8'h00;
        strobe_cnt   <= strobe_cnt + 16'h0001;
        last_gap     <= idle_q;
        last_lead    <= run_now;
        last_trail   <= 4'h0;
        trail_open_q <= 1'b1;
        last_cs_n    <= space_select_n;
        last_kind    <= {!read_strobe_n, !write_strobe_upper_n, !write_strobe_lower_n};
        last_word    <= bus_word;
        if (space_select_n == 4'hF) begin
          outside_cnt <= outside_cnt + 8'h01; // Strobe seen with no space selected
        end
      end else begin
        idle_q <= idle_q + {7'h00, space_select_n == 4'hF};
        if (trail_open_q && space_select_n == last_cs_n) begin
          last_trail <= last_trail + 4'h1;
        end else begin
          trail_open_q <= 1'b0;
        end
      end
    end
  end
endmodule

// [tb_external_space_timing_config.sv]
module tb_external_space_timing_config;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] WID = esc_pkg::OFS_SPACE_WIDTH_SELECT;
  localparam logic [11:0] TIM = esc_pkg::OFS_SPACE_CYCLE_TIMING;
  logic        pclk = 1'b0, presetn = 1'b0, manual_rst_n = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0]  pstrb = 4'h0;
  logic        rom_enabled = 1'b1, mode_space0_word = 1'b0;
  logic        acc_valid = 1'b0, acc_write = 1'b0, acc_upper = 1'b0, acc_lower = 1'b0;
  logic [1:0]  acc_space = 2'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, acc_ready, read_strobe_n, write_strobe_upper_n, write_strobe_lower_n, bus_word;
  logic [3:0]  space_select_n, last_lead, last_trail, last_cs_n;
  logic [15:0] strobe_cnt;
  logic [7:0]  last_gap, outside_cnt;
  logic [2:0]  last_kind;
  logic        last_word;
  int          errors = 0;
  int          samples_checked = 0;

  esc_space_timing i_dut (.pclk, .presetn, .manual_rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .rom_enabled, .mode_space0_word, .acc_valid, .acc_space, .acc_write, .acc_upper,
    .acc_lower, .acc_ready, .space_select_n, .read_strobe_n, .write_strobe_upper_n, .write_strobe_lower_n, .bus_word);
  esc_ext_mem_model i_mem (.pclk, .presetn, .space_select_n, .read_strobe_n, .write_strobe_upper_n,
    .write_strobe_lower_n, .bus_word, .strobe_cnt, .last_gap, .last_lead, .last_trail, .last_cs_n, .last_kind,
    .last_word, .outside_cnt);

  // ****************************************************************
  // Clock, watchdog and shared tasks
  // ****************************************************************
  always #4 pclk = ~pclk;

  // Cut a hang short
  initial begin
    #400000;
    errors++;
    $display("BAD watchdog expected finish seen timeout");
    results();
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    pstrb   <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk("apb ready", 32'h1, {31'h0, pready});
    @(posedge pclk);
  endtask

  task automatic wreg(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rreg(input string what, input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 16'h0000, rd, err);
    chk(what, exp, rd);
    chk("apb error", {31'h0, exp_err}, {31'h0, err});
  endtask

  // Reads use both lanes; writes use the lower lane on spaces 0 and 1, the upper lane on spaces 2 and 3
  task automatic acc(input logic [1:0] s, input logic w);
    int n;
    acc_valid <= 1'b1;
    acc_space <= s;
    acc_write <= w;
    acc_upper <= !w || s[1];
    acc_lower <= !w || !s[1];
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (acc_ready !== 1'b1 && n < 40);
    chk("acc taken", 32'h1, {31'h0, acc_ready});
  endtask

  // Release the request, wait for the strobes, then let any owed gap run out
  task automatic acc_done(input int c0, input int cnt);
    int n;
    acc_valid <= 1'b0;
    n = 0;
    while (strobe_cnt != c0 + cnt && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk("strobe count", c0 + cnt, strobe_cnt);
    repeat (6) @(posedge pclk);
  endtask

  function automatic logic [31:0] gap_exp(logic [15:0] t, int s1, logic w1, int s2, logic w2);
    logic [31:0] iw;
    logic [31:0] cw;
    iw = {30'h0, t[8 + 2 * s1 +: 2]};
    cw = {31'h0, t[4 + s1]};
    if (s1 == s2) return (!w1 && w2 && iw > cw) ? iw : cw;
    return w1 ? 32'h0 : iw;
  endfunction

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    rreg("width reset", WID, 32'h0000000F, 1'b0);
    rreg("timing reset", TIM, 32'h0000FFFF, 1'b0);
    rreg("unmapped", 12'h008, 32'h00000000, 1'b1);
    wreg(WID, 16'h0005);
    rreg("width written", WID, 32'h00000005, 1'b0);
    wreg(TIM, 16'h1234);
    manual_rst_n <= 1'b0;
    repeat (2) @(posedge pclk);
    manual_rst_n <= 1'b1;
    @(posedge pclk);
    rreg("timing kept", TIM, 32'h00001234, 1'b0);
    rreg("width kept", WID, 32'h00000005, 1'b0);
  endtask

  task automatic t_ext(input logic [15:0] t);
    int c0;
    wreg(TIM, t);
    for (int s = 0; s < 4; s++) begin
      for (int w = 0; w < 2; w++) begin
        c0 = strobe_cnt;
        acc(2'(s), w[0]);
        acc_done(c0, 1);
        chk("lead", t[s] ? 2 : 1, last_lead);
        chk("trail", t[s] ? 1 : 0, last_trail);
        chk("select", ~(4'h1 << s) & 4'hF, last_cs_n);
        chk("width", (5 >> s) & 1, last_word);
        chk("lanes", w ? ((((5 >> s) & 1) && s > 1) ? 2 : 1) : 4, last_kind);
      end
    end
    chk("outside", 0, outside_cnt);
  endtask

  task automatic t_mode();
    int c0;
    rom_enabled <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      mode_space0_word <= m[0];
      c0 = strobe_cnt;
      acc(2'h0, 1'b0);
      acc_done(c0, 1);
      chk("mode width", m, last_word);
    end
    rom_enabled <= 1'b1;
  endtask

  task automatic t_gap(input logic [15:0] t);
    int c0;
    wreg(TIM, t);
    for (int s1 = 0; s1 < 4; s1++) begin
      for (int s2 = 0; s2 < 4; s2++) begin
        for (int k = 0; k < 4; k++) begin
          c0 = strobe_cnt;
          acc(2'(s1), k[1]);
          acc(2'(s2), k[0]);
          acc_done(c0, 2);
          chk("gap", gap_exp(t, s1, k[1], s2, k[0]), last_gap);
        end
      end
    end
  endtask

  task automatic t_por();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rreg("width power on", WID, 32'h0000000F, 1'b0);
    rreg("timing power on", TIM, 32'h0000FFFF, 1'b0);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_ext(16'hE45A);
    t_ext(16'h0005);
    t_mode();
    t_gap(16'h1B00);
    t_gap(16'hE4FF);
    t_gap(16'h00F0);
    t_gap(16'h4E5A);
    t_por();
    results();
  end
endmodule
